/* hdl/fepcs_codec_top.sv */
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "fepcs_defs.svh"

module fepcs_codec_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Symbol clock from the link, sampled here.
	input wire logic linkClk,
	// MII transmit side.
	input wire logic txEn,
	input wire logic txEr,
	input wire logic [3:0] txData,
	// MII receive side.
	output logic [3:0] rxData,
	output logic rxEr,
	output logic rxDv,
	output logic rxClk,
	output logic crs,
	output logic col,
	output logic rxOutEnN,
	// Line code groups.
	input wire logic [4:0] lineRxCode,
	output logic [4:0] lineTxCode,
	// Mode pins and straps.
	input wire logic loopbackSelect,
	input wire logic alignBypassSelect,
	input wire logic coderBypassSelect,
	input wire logic serialTenSelect,
	input wire logic repeaterSelect,
	input wire logic rxEnable
);
	import fepcs_pkg::*;

	// ------------------------------------------------------------------------
	// Block state
	// ------------------------------------------------------------------------
	fepcs_state_s st_q; // Registered state.
	fepcs_state_s st_d; // Its next value.

	// ------------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------------
	logic linkEdge; // Rising edge of the sampled link clock.
	logic alignBp; // Align bypass active.
	logic coderBp; // Coder bypass active.
	logic serialMode; // Serial ten strap high; the 100 path stays idle.
	logic repMode; // Five-bit repeater interface.
	logic repCrs; // Repeater carrier sense function.
	logic localLb; // Local loopback.
	logic remoteLb; // Remote loopback.
	logic errSel; // Code error report select.
	logic [4:0] txSym; // Code group chosen for this symbol.
	logic [4:0] txLine; // Code group after scrambling and NRZI.
	logic [4:0] rxIn; // Receive path input, line or looped.
	logic [4:0] rxCode; // Received code group after descrambling.
	logic [4:0] dec; // Decoder answer {hit, nibble}.
	logic [7:0] regIdx; // Register index from the bus address.
	logic regHit; // Address maps to a register.
	logic [15:0] regRead; // Addressed register contents.
	logic rxActive; // Receive activity for carrier sense.

	assign linkEdge = st_q.s2.linkClk & ~st_q.linkPrev;
	// Pins and register bits are ORed together.
	assign alignBp = st_q.s2.alignPin | st_q.lbk[`FEPCS_LBK_ALIGN];
	assign coderBp = st_q.s2.coderPin | st_q.lbk[`FEPCS_LBK_CODER];
	assign serialMode = st_q.s2.serialPin;
	assign repMode = (alignBp | coderBp) & ~serialMode;
	assign repCrs = st_q.s2.repPin | st_q.pcs[`FEPCS_PCS_REPEATER];
	// Local loopback from any of its three sources.
	assign localLb = st_q.s2.lbPin | st_q.ctl[`FEPCS_CTRL_LOOP]
		| (st_q.lbk[`FEPCS_LBK_PMD] & st_q.lbk[`FEPCS_LBK_LOCAL]);
	// Both bits set is undefined; remote is then simply held off.
	assign remoteLb = st_q.lbk[`FEPCS_LBK_REMOTE] & ~st_q.lbk[`FEPCS_LBK_PMD];
	assign errSel = st_q.lbk[`FEPCS_LBK_ERRSEL];
	// The looped path takes the scrambled symbol of the same step, so both
	// LFSRs stay in lock.
	assign rxIn = localLb ? txLine : st_q.s2.lineRx;
	assign dec = fepcs_dec(rxCode);
	assign regIdx = paddr[9:2];

	// ------------------------------------------------------------------------
	// Scrambler paths; align bypass skips scrambler and NRZI
	// ------------------------------------------------------------------------
	fepcs_line_path u_tx_path (
		.clk(clk),
		.rst(rst),
		.step(linkEdge),
		.dirTx(1'b1),
		.scrBypass(alignBp | st_q.lbk[`FEPCS_LBK_SCR]),
		.nrziBypass(alignBp),
		.din(txSym),
		.dout(txLine)
	);

	fepcs_line_path u_rx_path (
		.clk(clk),
		.rst(rst),
		.step(linkEdge),
		.dirTx(1'b0),
		.scrBypass(alignBp | st_q.lbk[`FEPCS_LBK_SCR]),
		.nrziBypass(alignBp),
		.din(rxIn),
		.dout(rxCode)
	);

	// ------------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------------
	// Status is read-only and shows the live mode decode.
	always_comb
	begin
		regHit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
		regRead = 16'h0000;
		case (regIdx)
			`FEPCS_IDX_CTRL: regRead = st_q.ctl;
			`FEPCS_IDX_PCS: regRead = st_q.pcs;
			`FEPCS_IDX_LBK: regRead = st_q.lbk;
			`FEPCS_IDX_STAT: regRead = {7'h00,
				st_q.lbk[`FEPCS_LBK_REMOTE] & st_q.lbk[`FEPCS_LBK_PMD],
				st_q.txState != TX_IDLE, st_q.rxState != RX_IDLE, serialMode,
				repCrs, coderBp, alignBp, remoteLb, localLb};
			default: regHit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// Transmit symbol choice
	// ------------------------------------------------------------------------
	// Start and end groups follow the framing state and txEn, never the nibble
	// or error inputs.
	always_comb
	begin
		txSym = `FEPCS_CODE_I;
		if (serialMode)
		begin
			txSym = `FEPCS_CODE_I;
		end
		else if (repMode)
		begin
			txSym = {st_q.s2.txEr, st_q.s2.txData};
		end
		else
		begin
			case (st_q.txState)
				TX_IDLE: txSym = st_q.s2.txEn ? `FEPCS_CODE_J : `FEPCS_CODE_I;
				TX_K: txSym = `FEPCS_CODE_K;
				TX_DATA:
				begin
					if (!st_q.s2.txEn)
					begin
						txSym = `FEPCS_CODE_T;
					end
					else if (st_q.s2.txEr)
					begin
						txSym = `FEPCS_CODE_H;
					end
					else
					begin
						txSym = fepcs_enc(st_q.s2.txData);
					end
				end
				TX_R: txSym = `FEPCS_CODE_R;
				default: txSym = `FEPCS_CODE_I;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		rxActive = 1'b0;
		// Synchronisers for every pin but the APB port, clk and rst; the link clock is synchronised too.
		st_d.s1.txData = txData;
		st_d.s1.txEr = txEr;
		st_d.s1.txEn = txEn;
		st_d.s1.lineRx = lineRxCode;
		st_d.s1.rxEn = rxEnable;
		st_d.s1.lbPin = loopbackSelect;
		st_d.s1.alignPin = alignBypassSelect;
		st_d.s1.coderPin = coderBypassSelect;
		st_d.s1.serialPin = serialTenSelect;
		st_d.s1.repPin = repeaterSelect;
		st_d.s1.linkClk = linkClk;
		st_d.s2 = st_q.s1;
		st_d.linkPrev = st_q.s2.linkClk;
		st_d.rxClk = st_q.s2.linkClk;
		st_d.rxOeN = ~st_q.s2.rxEn;
		// APB: one wait cycle, then the answer; writes land at completion.
		st_d.pready = psel & penable & ~st_q.pready;
		if (psel && penable && !st_q.pready)
		begin
			st_d.pslverr = ~regHit;
			st_d.prdata = pwrite ? 32'h0000_0000 : {16'h0000, regRead};
		end
		if (psel && penable && st_q.pready && pwrite && regHit)
		begin
			case (regIdx)
				`FEPCS_IDX_CTRL: st_d.ctl = pwdata[15:0] & `FEPCS_CTRL_WMASK;
				`FEPCS_IDX_PCS: st_d.pcs = pwdata[15:0] & `FEPCS_PCS_WMASK;
				`FEPCS_IDX_LBK: st_d.lbk = pwdata[15:0] & `FEPCS_LBK_WMASK;
				default: st_d.lbk = st_q.lbk;
			endcase
		end
		if (linkEdge)
		begin
			// Transmit framing.
			st_d.txSym = txSym;
			st_d.lineTx = remoteLb ? st_q.s2.lineRx : (localLb ? 5'h00 : txLine);
			case (st_q.txState)
				TX_IDLE: st_d.txState = (st_q.s2.txEn && !repMode && !serialMode) ? TX_K : TX_IDLE;
				TX_K: st_d.txState = TX_DATA;
				TX_DATA: st_d.txState = st_q.s2.txEn ? TX_DATA : TX_R;
				TX_R: st_d.txState = TX_IDLE;
				default: st_d.txState = TX_IDLE;
			endcase
			// Receive decoding.
			st_d.rxDv = 1'b0;
			st_d.rxEr = 1'b0;
			st_d.rxData = 4'h0;
			if (serialMode)
			begin
				st_d.rxState = RX_IDLE;
			end
			else if (repMode)
			begin
				// Raw code group; bit five rides on the error pin.
				st_d.rxData = rxCode[3:0];
				st_d.rxEr = rxCode[4];
				st_d.rxDv = rxCode != `FEPCS_CODE_I;
				st_d.rxState = RX_IDLE;
				rxActive = rxCode != `FEPCS_CODE_I;
			end
			else
			begin
				case (st_q.rxState)
					// Idle keeps valid low.
					RX_IDLE: st_d.rxState = (rxCode == `FEPCS_CODE_J) ? RX_GOTJ : RX_IDLE;
					RX_GOTJ:
					begin
						if (rxCode == `FEPCS_CODE_K)
						begin
							st_d.rxState = RX_DATA;
							st_d.rxDv = 1'b1;
							st_d.rxData = `FEPCS_NIB_SSD;
						end
						else
						begin
							st_d.rxState = RX_IDLE;
						end
					end
					RX_DATA:
					begin
						st_d.rxDv = 1'b1;
						if (rxCode == `FEPCS_CODE_T)
						begin
							st_d.rxDv = 1'b0;
							st_d.rxState = RX_END;
						end
						else if (dec[4])
						begin
							st_d.rxData = dec[3:0];
						end
						else if (rxCode == `FEPCS_CODE_I || rxCode == `FEPCS_CODE_J
							|| rxCode == `FEPCS_CODE_K || rxCode == `FEPCS_CODE_R
							|| rxCode == `FEPCS_CODE_H)
						begin
							// Control inside the frame is a violation.
							st_d.rxData = `FEPCS_NIB_CTRLERR;
							st_d.rxEr = 1'b1;
							st_d.rxState = (rxCode == `FEPCS_CODE_I) ? RX_IDLE : RX_DATA;
						end
						else
						begin
							st_d.rxData = errSel ? `FEPCS_NIB_INVREP : `FEPCS_NIB_INV;
							st_d.rxEr = 1'b1;
						end
					end
					RX_END: st_d.rxState = RX_IDLE;
					default: st_d.rxState = RX_IDLE;
				endcase
				rxActive = st_d.rxState != RX_IDLE;
			end
			// Repeater carrier sense reflects receive only; MII adds transmit.
			st_d.crs = repCrs ? rxActive : (rxActive | st_q.s2.txEn);
			st_d.col = rxActive & st_q.s2.txEn & ~serialMode;
		end
	end

	// ------------------------------------------------------------------------
	// State register; mode bits clear on reset
	// ------------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign rxData = st_q.rxData;
	assign rxEr = st_q.rxEr;
	assign rxDv = st_q.rxDv;
	assign rxClk = st_q.rxClk;
	assign crs = st_q.crs;
	assign col = st_q.col;
	assign rxOutEnN = st_q.rxOeN;
	assign lineTxCode = st_q.lineTx;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	logic miiEdge; // Symbol step in 4B5B mode.
	assign miiEdge = linkEdge & ~repMode & ~serialMode;

	sequence s_ssd;
		(st_q.txSym == `FEPCS_CODE_J) && (st_q.txState == TX_K);
	endsequence

	sequence s_esd;
		(st_q.txSym == `FEPCS_CODE_T) && (st_q.txState == TX_R);
	endsequence

	property p_data_valid;
		@(posedge clk) disable iff (rst)
		(miiEdge && st_q.rxState == RX_DATA && dec[4])
		|=> (st_q.rxDv && !st_q.rxEr && st_q.rxData == $past(dec[3:0]));
	endproperty
	a_data_valid: assert property (p_data_valid) else $error("data group not valid");

	property p_start;
		@(posedge clk) disable iff (rst)
		(miiEdge && st_q.txState == TX_IDLE && st_q.s2.txEn) |=> s_ssd;
	endproperty
	a_start: assert property (p_start) else $error("no start group");

	property p_end;
		@(posedge clk) disable iff (rst)
		(miiEdge && st_q.txState == TX_DATA && !st_q.s2.txEn) |=> s_esd;
	endproperty
	a_end: assert property (p_end) else $error("no end group");

	property p_idle;
		@(posedge clk) disable iff (rst)
		(miiEdge && st_q.rxState == RX_IDLE) |=> !st_q.rxDv;
	endproperty
	a_idle: assert property (p_idle) else $error("valid high in idle");

	property p_hgroup;
		@(posedge clk) disable iff (rst)
		(miiEdge && st_q.rxState == RX_DATA && rxCode == `FEPCS_CODE_H)
		|=> (st_q.rxEr && st_q.rxData == `FEPCS_NIB_CTRLERR);
	endproperty
	a_hgroup: assert property (p_hgroup) else $error("H group not flagged");

	property p_invalid;
		@(posedge clk) disable iff (rst)
		(miiEdge && st_q.rxState == RX_DATA && !dec[4] && rxCode == 5'h00)
		|=> (st_q.rxEr && st_q.rxData == ($past(errSel) ? 4'h6 : 4'h5));
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid group nibble");

	property p_bit_five;
		@(posedge clk) disable iff (rst)
		(linkEdge && repMode) |=> (st_q.rxEr == $past(rxCode[4])
			&& st_q.rxData == $past(rxCode[3:0]));
	endproperty
	a_bit_five: assert property (p_bit_five) else $error("fifth bit lost");

	property p_align_raw;
		@(posedge clk) disable iff (rst)
		(linkEdge && alignBp && !serialMode)
		|-> (txLine == {st_q.s2.txEr, st_q.s2.txData});
	endproperty
	a_align_raw: assert property (p_align_raw) else $error("align path not raw");

	property p_rx_gate;
		@(posedge clk) disable iff (rst)
		st_q.s2.rxEn ##1 st_q.s2.rxEn |=> !st_q.rxOeN;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("outputs not enabled");

endmodule : fepcs_codec_top

/* hdl/fepcs_defs.svh */
`ifndef FEPCS_DEFS_SVH
`define FEPCS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define FEPCS_IDX_CTRL 8'h00
`define FEPCS_IDX_PCS 8'h17
`define FEPCS_IDX_LBK 8'h18
`define FEPCS_IDX_STAT 8'h1F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FEPCS_CTRL_LOOP 14
`define FEPCS_PCS_REPEATER 12
`define FEPCS_LBK_ERRSEL 0
`define FEPCS_LBK_PMD 8
`define FEPCS_LBK_REMOTE 9
`define FEPCS_LBK_LOCAL 11
`define FEPCS_LBK_ALIGN 12
`define FEPCS_LBK_SCR 13
`define FEPCS_LBK_CODER 14

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define FEPCS_CTRL_WMASK 16'h4000
`define FEPCS_PCS_WMASK 16'h1000
`define FEPCS_LBK_WMASK 16'h7B01
`define FEPCS_REG_RESET 16'h0000
`define FEPCS_LFSR_SEED 11'h7FF

// ----------------------------------------------------------------------------
// Code groups and nibbles
// ----------------------------------------------------------------------------
`define FEPCS_CODE_I 5'h1F
`define FEPCS_CODE_J 5'h18
`define FEPCS_CODE_K 5'h11
`define FEPCS_CODE_T 5'h0D
`define FEPCS_CODE_R 5'h07
`define FEPCS_CODE_H 5'h04
`define FEPCS_NIB_SSD 4'h5
`define FEPCS_NIB_CTRLERR 4'h0
`define FEPCS_NIB_INV 4'h5
`define FEPCS_NIB_INVREP 4'h6

`endif

/* hdl/fepcs_pkg.sv */
package fepcs_pkg;

	// ------------------------------------------------------------------------
	// State enumerations
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fepcs_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_GOTJ, RX_DATA, RX_END} fepcs_rx_e;

	// ------------------------------------------------------------------------
	// Synchroniser stage, one field per external input outside the APB port, clk and rst
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] txData;
		logic txEr;
		logic txEn;
		logic [4:0] lineRx;
		logic rxEn;
		logic lbPin;
		logic alignPin;
		logic coderPin;
		logic serialPin;
		logic repPin;
		logic linkClk;
	} fepcs_pins_s;

	// ------------------------------------------------------------------------
	// Line path state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [10:0] lfsr;
		logic lastLevel;
	} fepcs_lp_s;

	// ------------------------------------------------------------------------
	// Whole state of the codec top, registered as one word
	// ------------------------------------------------------------------------
	typedef struct packed {
		fepcs_pins_s s1; // First synchroniser stage, read only by s2.
		fepcs_pins_s s2; // Second synchroniser stage.
		logic linkPrev; // Previous sampled link clock.
		logic [15:0] ctl; // Basic control register.
		logic [15:0] pcs; // PCS configuration register.
		logic [15:0] lbk; // Loopback, bypass and error mask register.
		logic [31:0] prdata; // Read data.
		logic pready; // Access answer.
		logic pslverr; // Unmapped access.
		fepcs_tx_e txState; // Transmit framing state.
		logic [4:0] txSym; // Last code group sent, before scrambling.
		logic [4:0] lineTx; // Line code group output.
		fepcs_rx_e rxState; // Receive framing state.
		logic [3:0] rxData; // Receive nibble or low code bits.
		logic rxEr; // Receive error or fifth code bit.
		logic rxDv; // Receive data valid.
		logic crs; // Carrier sense.
		logic col; // Collision.
		logic rxClk; // Receive clock echo.
		logic rxOeN; // Receive output enable, low drives.
	} fepcs_state_s;

	// ------------------------------------------------------------------------
	// 4B5B data encoder; decoding searches the same table.
	// ------------------------------------------------------------------------
	function automatic logic [4:0] fepcs_enc(input logic [3:0] n);
		logic [4:0] c;
		c = 5'h1E;
		case (n)
			4'h0: c = 5'h1E;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0A;
			4'h5: c = 5'h0B;
			4'h6: c = 5'h0E;
			4'h7: c = 5'h0F;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'hA: c = 5'h16;
			4'hB: c = 5'h17;
			4'hC: c = 5'h1A;
			4'hD: c = 5'h1B;
			4'hE: c = 5'h1C;
			default: c = 5'h1D;
		endcase
		return c;
	endfunction : fepcs_enc

	// Returns {hit, nibble}; hit is low for anything but a data code group.
	function automatic logic [4:0] fepcs_dec(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int n = 0; n < 16; n++)
		begin
			if (fepcs_enc(4'(n)) == c)
			begin
				r = {1'b1, 4'(n)};
			end
		end
		return r;
	endfunction : fepcs_dec

endpackage : fepcs_pkg

/* hdl/fepcs_line_path.sv */
`timescale 1ns/1ps
`include "fepcs_defs.svh"

// Scrambler plus NRZI stage for one direction. On transmit it scrambles and
// then converts NRZ to NRZI; on receive it undoes both in reverse order.
module fepcs_line_path (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Symbol timing and path selection.
	input wire logic step,
	input wire logic dirTx,
	input wire logic scrBypass,
	input wire logic nrziBypass,
	// Code group in and out.
	input wire logic [4:0] din,
	output logic [4:0] dout
);
	import fepcs_pkg::*;

	// ------------------------------------------------------------------------
	// State and per-bit chains
	// ------------------------------------------------------------------------
	fepcs_lp_s st_q; // Registered state.
	fepcs_lp_s st_d; // Its next value.
	logic [10:0] lf [0:5]; // LFSR after each of five single steps.
	logic [4:0] key; // Scrambler key for this symbol.
	logic [5:0] lvl; // NRZI line levels; bit 0 is the level kept from the last symbol, bit 1 first on the wire.
	logic [4:0] nrzRx; // Receive bits after NRZI decoding.
	logic [4:0] scr; // Transmit bits after scrambling.

	assign lf[0] = st_q.lfsr;
	assign lvl[0] = st_q.lastLevel;
	assign scr = din ^ (scrBypass ? 5'h00 : key);

	// One generate loop builds the key, the transmit levels and the receive bits.
	genvar i;
	generate
		for (i = 0; i < 5; i++)
		begin : g_bit
			assign lf[i + 1] = {lf[i][9:0], lf[i][10] ^ lf[i][8]};
			assign key[i] = lf[i][10];
			assign lvl[i + 1] = lvl[i] ^ scr[i];
			if (i == 0)
			begin : g_first
				assign nrzRx[i] = din[i] ^ st_q.lastLevel;
			end
			else
			begin : g_rest
				assign nrzRx[i] = din[i] ^ din[i - 1];
			end
		end
	endgenerate

	// Output selection; the receive side descrambles after NRZI decoding.
	always_comb
	begin
		if (dirTx)
		begin
			dout = nrziBypass ? scr : lvl[5:1];
		end
		else
		begin
			dout = (nrziBypass ? din : nrzRx) ^ (scrBypass ? 5'h00 : key);
		end
	end

	// The LFSR advances one symbol per step; the last level is kept for NRZI.
	always_comb
	begin
		st_d = st_q;
		if (step)
		begin
			st_d.lfsr = lf[5];
			st_d.lastLevel = dirTx ? lvl[5] : din[4];
		end
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= {`FEPCS_LFSR_SEED, 1'b0};
		end
		else
		begin
			st_q <= st_d;
		end
	end

endmodule : fepcs_line_path

/* sim/fepcs_mac_model.sv */
`timescale 1ns/1ps
// MAC model: sends queued nibbles and keeps what arrives while valid or in error.
module fepcs_mac_model (
	// Clocks.
	input wire logic clk,
	input wire logic linkClk,
	// MII transmit.
	output logic txEn,
	output logic txEr,
	output logic [3:0] txData,
	// MII receive.
	input wire logic [3:0] rxData,
	input wire logic rxEr,
	input wire logic rxDv
);
	logic [4:0] txList[$]; // Pending {error, nibble}.
	logic [4:0] rxList[$]; // Arrivals {error, nibble}.
	logic linkClk_q = 1'h0; // Link clock one cycle ago.
	initial
	begin
		txEn = 1'h0;
		txEr = 1'h0;
		txData = 4'h0;
	end
	// Act on the link fall, half a symbol clear of the design's step.
	always @(posedge clk)
	begin
		linkClk_q <= linkClk;
		if (linkClk_q && !linkClk)
		begin
			if (rxDv || rxEr)
				rxList.push_back({rxEr, rxData});
			txEn <= txList.size() > 0;
			{txEr, txData} <= txList.size() > 0 ? txList.pop_front() : 5'h00;
		end
	end
endmodule : fepcs_mac_model

/* sim/fast_ethernet_pcs_codec_loopback_tb.sv */
`timescale 1ns/1ps
// Bench: APB tasks plus line and MII traffic with expected values.
module fast_ethernet_pcs_codec_loopback_tb;
	logic clk = 1'h0, rst = 1'h1, linkClk = 1'h0, rdErr;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic txEn, txEr, rxEr, rxDv, rxOutEnN, crs;
	logic lineLvl = 1'h0; // NRZI level last put on the line, as the receiver sees it.
	logic [3:0] txData, rxData;
	logic [4:0] lineRxCode = 5'h1F, lineTxCode;
	logic loopbackSelect = 1'h0, alignBypassSelect = 1'h0, coderBypassSelect = 1'h0;
	logic serialTenSelect = 1'h0, repeaterSelect = 1'h0, rxEnable = 1'h1;
	int badCount = 0, comparisons = 0;
	fepcs_codec_top u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .linkClk, .txEn, .txEr, .txData, .rxData, .rxEr, .rxDv,
		.rxClk(), .crs, .col(), .rxOutEnN, .lineRxCode, .lineTxCode, .loopbackSelect,
		.alignBypassSelect, .coderBypassSelect, .serialTenSelect, .repeaterSelect, .rxEnable);
	fepcs_mac_model u_mac (.clk, .linkClk, .txEn, .txEr, .txData, .rxData, .rxEr, .rxDv);
	// Core clock of 5 ns.
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// Link clock of 64 ns, offset so its edges never meet the core's.
	initial
	begin
		#1.3;
		forever #32 linkClk = ~linkClk;
	end
	// Counts one comparison and reports a mismatch.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			badCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Puts one NRZI coded group on the line after a link fall; it stays there until the next call.
	task automatic lineSym(input logic [4:0] code);
		logic [4:0] w;
		@(negedge linkClk);
		@(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			lineLvl = lineLvl ^ code[i];
			w[i] = lineLvl;
		end
		lineRxCode <= w;
	endtask : lineSym
	// One APB transfer, held until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rdata = prdata;
		rdErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Prints the counts and the verdict, then stops.
	task automatic finalReport();
		$display("comparisons %0d mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finalReport
	// Main sequence.
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		apb(1'h0, 8'h18, 32'h0);
		check(rdata, 32'h0);
		apb(1'h1, 8'h18, 32'hFFFF);
		apb(1'h0, 8'h18, 32'h0);
		check(rdata, 32'h7B01);
		apb(1'h0, 8'h3F, 32'h0);
		check(32'(rdErr), 32'h1);
		$display("registers done");
		// Align bypass from the register bit, then from the pin alone.
		for (int s = 0; s < 2; s++)
		begin
			apb(1'h1, 8'h18, s == 0 ? 32'h1000 : 32'h0);
			alignBypassSelect <= s == 1;
			repeaterSelect <= s == 1;
			for (int c = 3; c < 32; c += 7)
			begin
				lineRxCode <= 5'(c);
				repeat (6) u_mac.txList.push_back(5'(c ^ 5));
				repeat (30) @(posedge clk);
				check(32'({rxEr, rxData}), 32'(c));
				check(32'(rxDv), 32'(c != 31));
				check(32'(lineTxCode), 32'(c ^ 5));
				check(32'(crs), 32'(s == 0 || c != 31));
				u_mac.txList.delete();
			end
		end
		alignBypassSelect <= 1'h0;
		repeaterSelect <= 1'h0;
		$display("repeater done");
		// Local loopback from the pin, the control bit and bits 8 with 11.
		for (int s = 0; s < 3; s++)
		begin
			apb(1'h1, 8'h00, s == 1 ? 32'h4000 : 32'h0);
			apb(1'h1, 8'h18, s == 2 ? 32'h0900 : 32'h0);
			loopbackSelect <= s == 0;
			repeat (60) @(posedge clk);
			u_mac.rxList.delete();
			for (int i = 0; i < 10; i++)
				u_mac.txList.push_back(i < 2 ? 5'h05 : (i == 5 ? 5'h1F : 5'(i + 4)));
			repeat (300) @(posedge clk);
			while (u_mac.rxList.size() > 0 && u_mac.rxList[0] === 5'h05)
				void'(u_mac.rxList.pop_front());
			check(32'(u_mac.rxList.size()), 32'h8);
			for (int i = 2; i < 10; i++)
				check(32'(u_mac.rxList[i - 2]), i == 5 ? 32'h10 : 32'(i + 4));
			check(32'(rxDv), 32'h0);
		end
		loopbackSelect <= 1'h0;
		$display("local loopback done");
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h1, 8'h18, 32'h0200);
		lineRxCode <= 5'h0B;
		repeat (40) @(posedge clk);
		check(32'(lineTxCode), 32'h0B);
		rxEnable <= 1'h0;
		repeat (6) @(posedge clk);
		check(32'(rxOutEnN), 32'h1);
		$display("remote loopback and enable done");
		// Scrambler bypassed: idle, start pair, then an invalid group, both report modes.
		for (int e = 0; e < 2; e++)
		begin
			apb(1'h1, 8'h18, 32'h2000 | 32'(e));
			lineSym(5'h1F);
			lineSym(5'h1F);
			lineSym(5'h18);
			lineSym(5'h11);
			lineSym(5'h00);
			@(negedge linkClk);
			@(posedge clk);
			check(32'({rxEr, rxData}), e == 1 ? 32'h16 : 32'h15);
		end
		$display("line decode done");
		// Coder bypass pin alone gives repeater mode; the serial strap then idles receive.
		coderBypassSelect <= 1'h1;
		repeat (20) @(posedge clk);
		apb(1'h0, 8'h1F, 32'h0);
		check(rdata, 32'h8);
		serialTenSelect <= 1'h1;
		repeat (20) @(posedge clk);
		check(32'({rxDv, rxEr, rxData}), 32'h0);
		$display("modes done");
		finalReport();
	end
	// Cuts a hang short, far beyond the few thousand cycles expected.
	initial
	begin
		#100us;
		badCount++;
		finalReport();
	end
endmodule : fast_ethernet_pcs_codec_loopback_tb
